// file: inc/bsf_pkg.sv
// bsf_pkg: constants shared by the bit, shift and flag execution unit.
// assumes a single 200 MHz core clock and an avalon-mm register port.
`default_nettype none
package bsf_pkg;

  // datapath shape
  localparam int DATA_W      = 8;
  localparam int IDX_W       = 3;
  localparam int NUM_WREG    = 8;
  localparam int NUM_IO      = 8;
  localparam int STACK_DEPTH = 16;
  localparam int STACK_AW    = 4;
  localparam int OP_W        = 5;

  // bus shape and register byte offsets
  localparam int          AVS_AW        = 8;
  localparam int          AVS_DW        = 32;
  localparam logic [7:0]  OFF_CMD       = 8'h00;
  localparam logic [7:0]  OFF_STATUS    = 8'h04;
  localparam logic [7:0]  OFF_FLAGS     = 8'h08;
  localparam logic [7:0]  OFF_SP        = 8'h0C;
  localparam logic [7:0]  OFF_WREG_BASE = 8'h40;
  localparam logic [7:0]  OFF_IO_BASE   = 8'h80;
  localparam logic [7:0]  WIN_SEL_MASK  = 8'hE3;

  // command word fields
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_RD_LSB  = 8;
  localparam int CMD_RR_LSB  = 12;
  localparam int CMD_BIT_LSB = 16;

  // status word fields
  localparam int ST_OVF_BIT  = 0;
  localparam int ST_UNF_BIT  = 1;
  localparam int ST_CNT_LSB  = 8;

  // flags register bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // reset values
  localparam logic [7:0]  FLAGS_RST = 8'h00;
  localparam logic [7:0]  WREG_RST  = 8'h00;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // operation codes written into the command word
  localparam logic [4:0] OP_NOP      = 5'h00;
  localparam logic [4:0] OP_PORT_RD  = 5'h01;
  localparam logic [4:0] OP_PORT_WR  = 5'h02;
  localparam logic [4:0] OP_PUSH     = 5'h03;
  localparam logic [4:0] OP_POP      = 5'h04;
  localparam logic [4:0] OP_IO_SET   = 5'h05;
  localparam logic [4:0] OP_IO_CLR   = 5'h06;
  localparam logic [4:0] OP_SHL      = 5'h07;
  localparam logic [4:0] OP_SHR      = 5'h08;
  localparam logic [4:0] OP_RLC      = 5'h09;
  localparam logic [4:0] OP_RRC      = 5'h0A;
  localparam logic [4:0] OP_SRA      = 5'h0B;
  localparam logic [4:0] OP_SWAP     = 5'h0C;
  localparam logic [4:0] OP_FLAG_SET = 5'h0D;
  localparam logic [4:0] OP_FLAG_CLR = 5'h0E;
  localparam logic [4:0] OP_TSAVE    = 5'h0F;
  localparam logic [4:0] OP_TLOAD    = 5'h10;
  localparam logic [4:0] OP_SEC      = 5'h11;
  localparam logic [4:0] OP_CLC      = 5'h12;
  localparam logic [4:0] OP_SEN      = 5'h13;
  localparam logic [4:0] OP_CLN      = 5'h14;
  localparam logic [4:0] OP_SEZ      = 5'h15;
  localparam logic [4:0] OP_CLZ      = 5'h16;
  localparam logic [4:0] OP_SEI      = 5'h17;
  localparam logic [4:0] OP_CLI      = 5'h18;
  localparam logic [4:0] OP_SES      = 5'h19;
  localparam logic [4:0] OP_CLS      = 5'h1A;
  localparam logic [4:0] OP_SEV      = 5'h1B;
  localparam logic [4:0] OP_CLV      = 5'h1C;

endpackage : bsf_pkg
`default_nettype wire

// file: inc/bsf_core_if.sv
// bsf_core_if: wires between the unit's control and its shifter and stack.
// assumes all parties share the core clock.
`timescale 1ns/1ps
`default_nettype none
interface bsf_core_if;
  import bsf_pkg::*;
  logic [OP_W-1:0]     sh_op;
  logic [DATA_W-1:0]   sh_in;
  logic                sh_cin;
  logic [DATA_W-1:0]   sh_out;
  logic                sh_cout;
  logic                st_we;
  logic [STACK_AW-1:0] st_widx;
  logic [DATA_W-1:0]   st_wdata;
  logic [STACK_AW-1:0] st_ridx;
  logic [DATA_W-1:0]   st_rdata;

  modport core    (output sh_op, sh_in, sh_cin, st_we, st_widx, st_wdata, st_ridx,
                   input  sh_out, sh_cout, st_rdata);
  modport shifter (input  sh_op, sh_in, sh_cin, output sh_out, sh_cout);
  modport stack   (input  st_we, st_widx, st_wdata, st_ridx, output st_rdata);
endinterface : bsf_core_if
`default_nettype wire

// file: rtl/bsf_shift_unit.sv
// bsf_shift_unit: combinational shifts, rotates through carry and nibble swap.
// assumes the caller only commits the result for shift-class op codes.
`timescale 1ns/1ps
`default_nettype none
module bsf_shift_unit
(
  // link to control
  bsf_core_if.shifter bus
);
  import bsf_pkg::*;

  always_comb
  begin
    bus.sh_out  = bus.sh_in;
    bus.sh_cout = bus.sh_cin;
    case (bus.sh_op)
      OP_SHL  : bus.sh_out = {bus.sh_in[DATA_W-2:0], 1'b0};                   // see (RQ5)
      OP_SHR  : bus.sh_out = {1'b0, bus.sh_in[DATA_W-1:1]};                   // see (RQ5)
      OP_RLC  :
      begin
        bus.sh_out  = {bus.sh_in[DATA_W-2:0], bus.sh_cin};                    // see (RQ6)
        bus.sh_cout = bus.sh_in[DATA_W-1];                                    // see (RQ6)
      end
      OP_RRC  :
      begin
        bus.sh_out  = {bus.sh_cin, bus.sh_in[DATA_W-1:1]};                    // see (RQ7)
        bus.sh_cout = bus.sh_in[0];                                           // see (RQ7)
      end
      OP_SRA  : bus.sh_out = {bus.sh_in[DATA_W-1], bus.sh_in[DATA_W-1:1]};    // see (RQ8)
      OP_SWAP : bus.sh_out = {bus.sh_in[3:0], bus.sh_in[7:4]};                // see (RQ9)
      default : bus.sh_out = bus.sh_in;
    endcase
  end

endmodule : bsf_shift_unit
`default_nettype wire

// file: rtl/bsf_stack_mem.sv
// bsf_stack_mem: flip-flop stack storage, one write port, one read port.
// assumes control guards against overflow; read is combinational.
`timescale 1ns/1ps
`default_nettype none
module bsf_stack_mem
(
  // clock and reset
  input  wire logic   clk,
  input  wire logic   rst,
  // link to control
  bsf_core_if.stack   bus
);
  import bsf_pkg::*;

  logic [DATA_W-1:0] mem [STACK_DEPTH];

  genvar g;
  generate
    for (g = 0; g < STACK_DEPTH; g++)
    begin : g_ent
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          mem[g] <= WREG_RST;
        else if (bus.st_we && (bus.st_widx == STACK_AW'(g)))
          mem[g] <= bus.st_wdata;
      end
    end
  endgenerate

  assign bus.st_rdata = mem[bus.st_ridx];

endmodule : bsf_stack_mem
`default_nettype wire

// file: rtl/bsf_exec_unit.sv
// bsf_exec_unit: data-transfer, bit and bit-test execution for an 8-bit core,
// holding its own working registers, i/o locations, stack and flags register.
// assumes an avalon-mm master on the same clock that honours waitrequest.
//
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Operation
// (RQ1) A port read copies the selected i/o location into the destination working register.
// (RQ2) A port write copies the source working register into the selected i/o location.
// (RQ3) A stack store puts the source register on the stack and a stack load returns the top into the destination.
// (RQ4) An i/o bit set forces the chosen bit to one, a bit clear forces it to zero, other bits untouched.
// (RQ5) Logical left shift fills bit 0 with zero and logical right shift fills bit 7 with zero.
// (RQ6) Left rotate through carry takes old carry into bit 0 and old bit 7 into carry.
// (RQ7) Right rotate through carry takes old carry into bit 7 and old bit 0 into carry.
// (RQ8) Arithmetic right shift moves bits 7..1 down and keeps bit 7, preserving the sign.
// (RQ9) Nibble exchange swaps the low and high four bits of the destination.
// (RQ10) Generic flag set writes one to the chosen flag bit and generic flag clear writes zero.
// (RQ11) Bit store copies a source bit into the spare flag and bit load copies it back into a destination bit.
// (RQ12) Dedicated carry ops set or clear carry and leave every other flag alone.
// (RQ13) Dedicated ops set or clear the negative flag, and one clears the zero flag; the code also has OP_SEZ, which sets the zero flag.
// (RQ14) Global interrupt enable sets the interrupt flag and disable clears it.
// (RQ15) Dedicated ops set or clear the signed test flag.
// (RQ16) Dedicated ops set or clear the two's complement overflow flag.
// (RQ17) A stack store writes at the stack pointer then decrements it; a load increments first then reads.
module bsf_exec_unit
(
  // clock and reset
  input  wire logic                         REF_CLK,
  input  wire logic                         RST,
  // avalon-mm slave
  input  wire logic [bsf_pkg::AVS_AW-1:0]   AVS_ADDRESS,
  input  wire logic                         AVS_READ,
  input  wire logic                         AVS_WRITE,
  input  wire logic [bsf_pkg::AVS_DW-1:0]   AVS_WRITEDATA,
  input  wire logic [3:0]                   AVS_BYTEENABLE,
  output var  logic [bsf_pkg::AVS_DW-1:0]   AVS_READDATA,
  output var  logic                         AVS_WAITREQUEST
);
  import bsf_pkg::*;

  logic [DATA_W-1:0]   wreg   [NUM_WREG];
  logic [DATA_W-1:0]   io_reg [NUM_IO];
  logic [DATA_W-1:0]   flags;
  logic [STACK_AW:0]   stk_cnt;
  logic                st_ovf;
  logic                st_unf;

  logic                commit;
  logic [OP_W-1:0]     cmd_op;
  logic [IDX_W-1:0]    cmd_rd;
  logic [IDX_W-1:0]    cmd_rr;
  logic [IDX_W-1:0]    cmd_bit;
  logic [DATA_W-1:0]   rd_val;
  logic [DATA_W-1:0]   rr_val;
  logic [DATA_W-1:0]   port_val;
  logic [STACK_AW-1:0] sp_idx;
  logic                stk_full;
  logic                stk_empty;
  logic [IDX_W-1:0]    win_idx;
  logic                lane0;

  logic                wr_we;
  logic [IDX_W-1:0]    wr_idx;
  logic [DATA_W-1:0]   wr_val;
  logic                io_we;
  logic [IDX_W-1:0]    io_idx;
  logic [DATA_W-1:0]   io_val;
  logic                fl_we;
  logic [DATA_W-1:0]   fl_val;
  logic                push_ok;
  logic                pop_ok;
  logic                ovf_set;
  logic                unf_set;
  logic                ovf_clr;
  logic                unf_clr;
  logic [AVS_DW-1:0]   rd_mux;

  bsf_core_if cif ();

  bsf_shift_unit u_shift
  (
    .bus (cif.shifter)
  );

  bsf_stack_mem u_stack
  (
    .clk (REF_CLK),
    .rst (RST),
    .bus (cif.stack)
  );

  // command fields and operand selection
  assign commit    = AVS_WRITE && !AVS_WAITREQUEST;
  assign cmd_op    = AVS_WRITEDATA[CMD_OP_LSB +: OP_W];
  assign cmd_rd    = AVS_WRITEDATA[CMD_RD_LSB +: IDX_W];
  assign cmd_rr    = AVS_WRITEDATA[CMD_RR_LSB +: IDX_W];
  assign cmd_bit   = AVS_WRITEDATA[CMD_BIT_LSB +: IDX_W];
  assign rd_val    = wreg[cmd_rd];
  assign rr_val    = wreg[cmd_rr];
  assign port_val  = io_reg[cmd_rr];
  assign win_idx   = AVS_ADDRESS[IDX_W+1:2];
  assign lane0     = AVS_BYTEENABLE[0];
  // pointer sits one below the occupied entries; the top entry is at sp_idx + 1
  assign sp_idx    = STACK_AW'(STACK_DEPTH - 1) - stk_cnt[STACK_AW-1:0];
  assign stk_full  = (stk_cnt == (STACK_AW+1)'(STACK_DEPTH));
  assign stk_empty = (stk_cnt == '0);

  assign cif.sh_op    = cmd_op;
  assign cif.sh_in    = rd_val;
  assign cif.sh_cin   = flags[FLAG_C];
  assign cif.st_widx  = sp_idx;                                   // see (RQ17)
  assign cif.st_ridx  = sp_idx + STACK_AW'(1);                     // see (RQ17)
  assign cif.st_wdata = rr_val;
  assign cif.st_we    = push_ok;

  // decode of bus writes and commands into register updates
  always_comb
  begin
    wr_we   = 1'b0;
    wr_idx  = cmd_rd;
    wr_val  = rd_val;
    io_we   = 1'b0;
    io_idx  = cmd_rr;
    io_val  = port_val;
    fl_we   = 1'b0;
    fl_val  = flags;
    push_ok = 1'b0;
    pop_ok  = 1'b0;
    ovf_set = 1'b0;
    unf_set = 1'b0;
    ovf_clr = 1'b0;
    unf_clr = 1'b0;
    if (commit && (AVS_ADDRESS == OFF_CMD) && (&AVS_BYTEENABLE[2:0]))
    begin
      case (cmd_op)
        OP_PORT_RD  :
        begin
          wr_we  = 1'b1;
          wr_val = port_val;                                      // see (RQ1)
        end
        OP_PORT_WR  :
        begin
          io_we  = 1'b1;
          io_val = rr_val;                                        // see (RQ2)
        end
        OP_PUSH     :
        begin
          push_ok = !stk_full;                                    // see (RQ3)
          ovf_set = stk_full;
        end
        OP_POP      :
        begin
          pop_ok  = !stk_empty;
          unf_set = stk_empty;
          wr_we   = !stk_empty;
          wr_val  = cif.st_rdata;                                 // see (RQ3)
        end
        OP_IO_SET, OP_IO_CLR :
        begin
          io_we           = 1'b1;
          io_val[cmd_bit] = (cmd_op == OP_IO_SET);  // see (RQ4)
        end
        // non-rotates pass carry through
        OP_SHL, OP_SHR, OP_RLC, OP_RRC, OP_SRA, OP_SWAP :
        begin
          wr_we          = 1'b1;
          wr_val         = cif.sh_out;            // see (RQ5) (RQ8) (RQ9)
          fl_we          = 1'b1;
          fl_val[FLAG_C] = cif.sh_cout;           // see (RQ6) (RQ7)
        end
        OP_FLAG_SET, OP_FLAG_CLR :
        begin
          fl_we           = 1'b1;
          fl_val[cmd_bit] = (cmd_op == OP_FLAG_SET);  // see (RQ10)
        end
        OP_TSAVE    :
        begin
          fl_we          = 1'b1;
          fl_val[FLAG_T] = rr_val[cmd_bit];                       // see (RQ11)
        end
        OP_TLOAD    :
        begin
          wr_we           = 1'b1;
          wr_val[cmd_bit] = flags[FLAG_T];                        // see (RQ11)
        end
        OP_SEC, OP_CLC :
        begin
          fl_we          = 1'b1;
          fl_val[FLAG_C] = (cmd_op == OP_SEC);                    // see (RQ12)
        end
        OP_SEN, OP_CLN :
        begin
          fl_we          = 1'b1;
          fl_val[FLAG_N] = (cmd_op == OP_SEN);                    // see (RQ13)
        end
        OP_SEZ, OP_CLZ :
        begin
          fl_we          = 1'b1;
          fl_val[FLAG_Z] = (cmd_op == OP_SEZ);                    // see (RQ13)
        end
        OP_SEI, OP_CLI :
        begin
          fl_we          = 1'b1;
          fl_val[FLAG_I] = (cmd_op == OP_SEI);                    // see (RQ14)
        end
        OP_SES, OP_CLS :
        begin
          fl_we          = 1'b1;
          fl_val[FLAG_S] = (cmd_op == OP_SES);                    // see (RQ15)
        end
        OP_SEV, OP_CLV :
        begin
          fl_we          = 1'b1;
          fl_val[FLAG_V] = (cmd_op == OP_SEV);                    // see (RQ16)
        end
        default     : fl_we = 1'b0;
      endcase
    end
    else if (commit && lane0 && (AVS_ADDRESS == OFF_STATUS))
    begin
      ovf_clr = AVS_WRITEDATA[ST_OVF_BIT];
      unf_clr = AVS_WRITEDATA[ST_UNF_BIT];
    end
    else if (commit && lane0 && (AVS_ADDRESS == OFF_FLAGS))
    begin
      fl_we  = 1'b1;
      fl_val = AVS_WRITEDATA[DATA_W-1:0];
    end
    else if (commit && lane0 && ((AVS_ADDRESS & WIN_SEL_MASK) == OFF_WREG_BASE))
    begin
      wr_we  = 1'b1;
      wr_idx = win_idx;
      wr_val = AVS_WRITEDATA[DATA_W-1:0];
    end
    else if (commit && lane0 && ((AVS_ADDRESS & WIN_SEL_MASK) == OFF_IO_BASE))
    begin
      io_we  = 1'b1;
      io_idx = win_idx;
      io_val = AVS_WRITEDATA[DATA_W-1:0];
    end
  end

  // read mux; unmapped addresses read as zero
  always_comb
  begin
    rd_mux = '0;
    if (AVS_ADDRESS == OFF_STATUS)
    begin
      rd_mux[ST_OVF_BIT]               = st_ovf;
      rd_mux[ST_UNF_BIT]               = st_unf;
      rd_mux[ST_CNT_LSB +: STACK_AW+1] = stk_cnt;
    end
    else if (AVS_ADDRESS == OFF_FLAGS)
      rd_mux[DATA_W-1:0] = flags;
    else if (AVS_ADDRESS == OFF_SP)
      rd_mux[STACK_AW-1:0] = sp_idx;
    else if ((AVS_ADDRESS & WIN_SEL_MASK) == OFF_WREG_BASE)
      rd_mux[DATA_W-1:0] = wreg[win_idx];
    else if ((AVS_ADDRESS & WIN_SEL_MASK) == OFF_IO_BASE)
      rd_mux[DATA_W-1:0] = io_reg[win_idx];
  end

  // bus handshake: one wait cycle, then a one-cycle acknowledge
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      AVS_WAITREQUEST <= 1'b1;
    else
      AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST);
  end

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      AVS_READDATA <= RDATA_RST;
    else if (AVS_READ && AVS_WAITREQUEST)
      AVS_READDATA <= rd_mux;
  end

  // working registers and i/o locations
  genvar g;
  generate
    for (g = 0; g < NUM_WREG; g++)
    begin : g_wreg
      always_ff @(posedge REF_CLK or posedge RST)
      begin
        if (RST)
          wreg[g] <= WREG_RST;
        else if (wr_we && (wr_idx == IDX_W'(g)))
          wreg[g] <= wr_val;
      end
    end
    for (g = 0; g < NUM_IO; g++)
    begin : g_io
      always_ff @(posedge REF_CLK or posedge RST)
      begin
        if (RST)
          io_reg[g] <= WREG_RST;
        else if (io_we && (io_idx == IDX_W'(g)))
          io_reg[g] <= io_val;
      end
    end
  endgenerate

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      flags <= FLAGS_RST;
    else if (fl_we)
      flags <= fl_val;
  end

  // occupancy counter stands in for the pointer, so full and empty are exact
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      stk_cnt <= '0;
    else if (push_ok)
      stk_cnt <= stk_cnt + (STACK_AW+1)'(1);                     // see (RQ17)
    else if (pop_ok)
      stk_cnt <= stk_cnt - (STACK_AW+1)'(1);                     // see (RQ17)
  end

  // sticky stack errors; a new error beats a clear in the same cycle
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      st_ovf <= 1'b0;
      st_unf <= 1'b0;
    end
    else
    begin
      st_ovf <= ovf_set | (st_ovf & ~ovf_clr);
      st_unf <= unf_set | (st_unf & ~unf_clr);
    end
  end

endmodule : bsf_exec_unit
`default_nettype wire

// file: verif/bsf_exec_unit_assertions.sv
// bsf_exec_unit_assertions: bus handshake and flag checks on the unit's ports.
// assumes it is bound to bsf_exec_unit and sees every avalon-mm transfer.
`timescale 1ns/1ps
`default_nettype none
module bsf_exec_unit_assertions
(
  // clock and reset
  input wire logic                       REF_CLK,
  input wire logic                       RST,
  // avalon-mm slave
  input wire logic [bsf_pkg::AVS_AW-1:0] AVS_ADDRESS,
  input wire logic                       AVS_READ,
  input wire logic                       AVS_WRITE,
  input wire logic [bsf_pkg::AVS_DW-1:0] AVS_WRITEDATA,
  input wire logic [3:0]                 AVS_BYTEENABLE,
  input wire logic [bsf_pkg::AVS_DW-1:0] AVS_READDATA,
  input wire logic                       AVS_WAITREQUEST
);
  import bsf_pkg::*;
  logic            req;
  logic            done;
  logic            fl_rd;
  logic [OP_W-1:0] last_op;
  assign req   = AVS_READ | AVS_WRITE;
  assign done  = req & ~AVS_WAITREQUEST;
  assign fl_rd = done & AVS_READ & (AVS_ADDRESS == OFF_FLAGS);
  // other writes void the op: no stale flag checks
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      last_op <= OP_NOP;
    else if (done && AVS_WRITE && AVS_ADDRESS == OFF_CMD && AVS_BYTEENABLE[2:0] == 3'h7)
      last_op <= AVS_WRITEDATA[OP_W-1:0];
    else if (done && AVS_WRITE)
      last_op <= OP_NOP;
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  property p_wait_one; req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST; endproperty
  a_wait_one: assert property (p_wait_one) else $error("no answer one cycle after request");
  property p_wait_back; !AVS_WAITREQUEST |=> AVS_WAITREQUEST; endproperty
  a_wait_back: assert property (p_wait_back) else $error("waitrequest low for more than one cycle");
  property p_idle; !req |=> AVS_WAITREQUEST; endproperty
  a_idle: assert property (p_idle) else $error("waitrequest low without request");
  property p_rdata_hold; !AVS_READ |=> $stable(AVS_READDATA); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved between reads");
  property p_cmd_zero; done && AVS_READ && AVS_ADDRESS == OFF_CMD |-> AVS_READDATA == RDATA_RST; endproperty
  a_cmd_zero: assert property (p_cmd_zero) else $error("command word read not zero");
  property p_narrow; done && AVS_READ && AVS_ADDRESS[7:6] != 2'h0 |-> AVS_READDATA[31:8] == 24'h000000; endproperty
  a_narrow: assert property (p_narrow) else $error("upper read bits not zero");
  property p_carry_set; fl_rd && last_op == OP_SEC |-> AVS_READDATA[FLAG_C]; endproperty
  a_carry_set: assert property (p_carry_set) else $error("carry not set");
  property p_carry_clr; fl_rd && last_op == OP_CLC |-> !AVS_READDATA[FLAG_C]; endproperty
  a_carry_clr: assert property (p_carry_clr) else $error("carry not cleared");
  property p_neg_clr; fl_rd && last_op == OP_CLN |-> !AVS_READDATA[FLAG_N]; endproperty
  a_neg_clr: assert property (p_neg_clr) else $error("negative not cleared");
  property p_zero_clr; fl_rd && last_op == OP_CLZ |-> !AVS_READDATA[FLAG_Z]; endproperty
  a_zero_clr: assert property (p_zero_clr) else $error("zero not cleared");
  property p_int_set; fl_rd && last_op == OP_SEI |-> AVS_READDATA[FLAG_I]; endproperty
  a_int_set: assert property (p_int_set) else $error("interrupt flag not set");
  property p_sign_set; fl_rd && last_op == OP_SES |-> AVS_READDATA[FLAG_S]; endproperty
  a_sign_set: assert property (p_sign_set) else $error("sign flag not set");
  property p_ovf_clr; fl_rd && last_op == OP_CLV |-> !AVS_READDATA[FLAG_V]; endproperty
  a_ovf_clr: assert property (p_ovf_clr) else $error("overflow flag not cleared");
  c_write: cover property (done && AVS_WRITE);
  c_flags: cover property (fl_rd && last_op == OP_SEV);
  c_full: cover property (done && AVS_READ && AVS_ADDRESS == OFF_STATUS && AVS_READDATA[ST_OVF_BIT]);
endmodule : bsf_exec_unit_assertions
bind bsf_exec_unit bsf_exec_unit_assertions u_chk (.REF_CLK(REF_CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST));
`default_nettype wire

// file: verif/bsf_host_model.sv
// bsf_host_model: avalon-mm master standing for the core that drives the unit.
// assumes one shared clock; waits are cut short only by the bench watchdog.
`timescale 1ns/1ps
`default_nettype none
module bsf_host_model
(
  // clock
  input  wire logic                       clk,
  // avalon-mm master
  output var  logic [bsf_pkg::AVS_AW-1:0] address,
  output var  logic                       read,
  output var  logic                       write,
  output var  logic [bsf_pkg::AVS_DW-1:0] writedata,
  output var  logic [3:0]                 byteenable,
  input  wire logic [bsf_pkg::AVS_DW-1:0] readdata,
  input  wire logic                       waitrequest
);
  import bsf_pkg::*;
  logic [3:0] be_sel;
  initial
  begin
    {address, read, write, writedata} = '0;
    {byteenable, be_sel}              = 8'hFF;
  end
  // released lines show the inverse so stale use of them is caught
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    address    <= a;
    writedata  <= d;
    byteenable <= be_sel;
    write      <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    write      <= 1'b0;
    address    <= ~a;
    writedata  <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    address    <= a;
    byteenable <= 4'hF;
    read       <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    d = readdata;
    read       <= 1'b0;
    address    <= ~a;
  endtask : rd
endmodule : bsf_host_model
`default_nettype wire

// file: verif/testbench.sv
// testbench: random and corner-case checks of the bit, shift and flag unit.
// assumes the host model issues every transfer; no inputs are tied off.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import bsf_pkg::*;
  logic        clk;
  logic        rst;
  logic [7:0]  addr;
  logic        rd_en;
  logic        wr_en;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic [31:0] rdata;
  logic        wait_req;
  int          mismatches;
  int          num_checks;
  integer      seed;
  int          fb [6] = '{FLAG_C, FLAG_N, FLAG_Z, FLAG_I, FLAG_S, FLAG_V};
  bsf_exec_unit uut (.REF_CLK(clk), .RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd_en), .AVS_WRITE(wr_en),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req));
  bsf_host_model host (.clk(clk), .address(addr), .read(rd_en), .write(wr_en), .writedata(wdata),
    .byteenable(be), .readdata(rdata), .waitrequest(wait_req));
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    host.rd(a, d);
    chk(d, exp);
  endtask : rdchk
  task automatic cmd(input logic [4:0] op, input int d, input int r, input int b);
    host.wr(OFF_CMD, {13'h0, b[2:0], 1'b0, r[2:0], 1'b0, d[2:0], 3'h0, op});
  endtask : cmd
  function automatic logic [7:0] wa(input int i);
    return OFF_WREG_BASE + {3'h0, i[2:0], 2'h0};
  endfunction : wa
  function automatic logic [7:0] ia(input int i);
    return OFF_IO_BASE + {3'h0, i[2:0], 2'h0};
  endfunction : ia
  // bit 8 of the result is the carry after the op
  function automatic logic [8:0] shx(input logic [4:0] op, input logic [7:0] v, input logic c);
    case (op)
      OP_SHL:  return {c, v[6:0], 1'b0};
      OP_SHR:  return {c, 1'b0, v[7:1]};
      OP_RLC:  return {v[7], v[6:0], c};
      OP_RRC:  return {v[0], c, v[7:1]};
      OP_SRA:  return {c, v[7], v[7:1]};
      default: return {c, v[3:0], v[7:4]};
    endcase
  endfunction : shx
  initial
  begin
    repeat (30000) @(posedge clk);
    mismatches++;
    stop_test();
  end
  initial
  begin
    logic [7:0] stk [17];
    logic [7:0] v, f, w;
    logic [8:0] e;
    logic [31:0] rv;
    seed = 58;
    mismatches = 0;
    num_checks = 0;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rdchk(OFF_FLAGS, {24'h0, FLAGS_RST});
    rdchk(OFF_SP, 32'h0000_000F);
    rdchk(OFF_STATUS, 32'h0);
    rdchk(wa(0), {24'h0, WREG_RST});
    host.wr(8'h30, 32'hFFFF_FFFF);
    rdchk(8'h30, 32'h0);
    rdchk(OFF_CMD, 32'h0);
    // a command without its upper lanes must be dropped
    host.be_sel = 4'h1;
    cmd(OP_SEC, 0, 0, 0);
    host.be_sel = 4'hF;
    rdchk(OFF_FLAGS, 32'h0);
    for (int k = 0; k < 48; k++)
    begin
      v = (k < 6) ? 8'h81 : 8'($random(seed));
      f = 8'($random(seed));
      e = shx(OP_SHL + 5'(k % 6), v, f[FLAG_C]);
      host.wr(wa(k), {24'h0, v});
      host.wr(OFF_FLAGS, {24'h0, f});
      cmd(OP_SHL + 5'(k % 6), k, 0, 0);
      rdchk(wa(k), {24'h0, e[7:0]});
      rdchk(OFF_FLAGS, {24'h0, f[7:1], e[8]});
    end
    for (int k = 0; k < 8; k++)
    begin
      v = 8'($random(seed));
      host.wr(wa(k), {24'h0, v});
      cmd(OP_PORT_WR, 0, k, 0);
      rdchk(ia(k), {24'h0, v});
      cmd(OP_PORT_RD, 7 - k, k, 0);
      rdchk(wa(7 - k), {24'h0, v});
      cmd(OP_IO_SET, 0, k, 7 - k);
      v[7 - k] = 1'b1;
      rdchk(ia(k), {24'h0, v});
      cmd(OP_IO_CLR, 0, k, k);
      v[k] = 1'b0;
      rdchk(ia(k), {24'h0, v});
    end
    for (int k = 0; k < 17; k++)
    begin
      stk[k] = 8'($random(seed));
      host.wr(wa(2), {24'h0, stk[k]});
      cmd(OP_PUSH, 0, 2, 0);
      if (k < 15)
        rdchk(OFF_SP, 32'(14 - k));
    end
    rdchk(OFF_STATUS, 32'h0000_1001);
    host.wr(OFF_STATUS, 32'h3);
    for (int k = 15; k >= 0; k--)
    begin
      cmd(OP_POP, 3, 0, 0);
      rdchk(wa(3), {24'h0, stk[k]});
      rdchk(OFF_SP, 32'(15 - k));
    end
    cmd(OP_POP, 3, 0, 0);
    rdchk(wa(3), {24'h0, stk[0]});
    rdchk(OFF_STATUS, 32'h0000_0002);
    for (int k = 0; k < 8; k++)
    begin
      f = 8'($random(seed));
      host.wr(OFF_FLAGS, {24'h0, f});
      cmd(OP_FLAG_SET, 0, 0, k);
      f[k] = 1'b1;
      rdchk(OFF_FLAGS, {24'h0, f});
      cmd(OP_FLAG_CLR, 0, 0, k);
      f[k] = 1'b0;
      rdchk(OFF_FLAGS, {24'h0, f});
      v = 8'($random(seed));
      w = ~v;
      host.wr(wa(4), {24'h0, v});
      host.wr(wa(5), {24'h0, w});
      cmd(OP_TSAVE, 0, 4, k);
      host.rd(OFF_FLAGS, rv);
      chk({31'h0, rv[FLAG_T]}, {31'h0, v[k]});
      cmd(OP_TLOAD, 5, 0, k);
      w[k] = v[k];
      rdchk(wa(5), {24'h0, w});
    end
    for (int k = 0; k < 12; k++)
    begin
      f = 8'($random(seed));
      host.wr(OFF_FLAGS, {24'h0, f});
      cmd(OP_SEC + 5'(k), 0, 0, 0);
      f[fb[k / 2]] = ~k[0];
      rdchk(OFF_FLAGS, {24'h0, f});
    end
    stop_test();
  end
endmodule : testbench
`default_nettype wire
